// ---- src/fpc_opcode_decode.sv ----
// opcode decoder and sequencer of the real/integer coprocessor
// Function
// - groups 0,1 pick accumulator/operand; 2,3 also load a 4-byte value
// - group 5 picks operand and copies it into the accumulator
// - real groups pick operand then add/subtract/multiply/divide into acc
// - integer groups pick operand then signed add/subtract/multiply
// - integer divide picks operand, quotient to acc, remainder to reg 0
// - floor, ceiling and round replace the accumulator
// - radians-to-degrees and degrees-to-radians scale the accumulator
// - int-to-real and real-to-int convert a copy of acc into reg 0
// - byte/halfword loads extend by sign or zero, into reg 0 as real
// - text readout sends buffer characters through the zero terminator
// - text-to-number parses a zero-ended string into reg 0
// - number-to-text takes a format byte, fills the text buffer
// - real condition byte reports the accumulator's state
// - extension prefix makes the next byte an extended opcode
// - extended 0x00-0x3f call stored function by its low six bits
// - conditional opcodes take a byte; mismatch skips the function rest
// - conditional opcodes act only inside a stored function
// - busy stays high until every function opcode has finished
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_opcode_decode
  import fpc_pkg::*;
#(
  parameter int FMEM_AW = 10,
  parameter int STR_AW  = 5
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               hostValid,
  input  wire logic [7:0]         hostData,
  output logic                    hostReady,
  output logic                    outValid,
  output logic      [7:0]         outData,
  input  wire logic               outReady,
  output logic                    busy,
  output logic                    mathReq,
  output logic      [7:0]         mathOp,
  output logic      [31:0]        mathArgA,
  output logic      [31:0]        mathArgB,
  input  wire logic               mathDone,
  input  wire logic [31:0]        mathRes,
  input  wire logic [31:0]        mathRem,
  input  wire logic               progWe,
  input  wire logic [FMEM_AW-1:0] progAddr,
  input  wire logic [7:0]         progData
);
  fpc_state_e         state_r, state_nxt;
  fpc_want_e          want_r, want_nxt;
  logic [7:0]         op_r, op_nxt;
  logic [7:0]         xop_r, xop_nxt;
  logic [3:0]         accSel_r, accSel_nxt;
  logic [3:0]         opSel_r, opSel_nxt;
  logic [1:0]         cnt_r, cnt_nxt;
  logic [31:0]        word_r, word_nxt;
  logic [31:0]        accVal_r, accVal_nxt;
  logic [31:0]        mA_r, mA_nxt;
  logic [31:0]        mB_r, mB_nxt;
  logic [31:0]        wbVal_r, wbVal_nxt;
  logic [31:0]        rem_r, rem_nxt;
  logic [3:0]         dest_r, dest_nxt;
  logic [FMEM_AW-1:0] pc_r, pc_nxt;
  logic [7:0]         len_r, len_nxt;
  logic               inFunc_r, inFunc_nxt;
  logic [5:0]         fn_r, fn_nxt;
  logic [STR_AW-1:0]  strIdx_r, strIdx_nxt;

  logic               gotByte;
  logic [7:0]         gotData;
  logic [3:0]         gotNib;
  logic [3:0]         gotLo;
  logic [3:0]         opNib;
  logic [3:0]         opLo;
  logic               isLoad;
  logic               isTextIn;
  logic               isTextOut;
  logic               toReg0;
  logic               isCond;
  logic [31:0]        ldVal;
  logic [3:0]         opAddr;
  logic [2:0]         statCode;
  logic [7:0]         statByte;
  logic               condMatch;
  logic [FMEM_AW-1:0] fAddr;
  logic [7:0]         fData;
  logic [3:0]         regRAddr;
  logic [31:0]        regRData;
  logic               regWe;
  logic [3:0]         regWAddr;
  logic [31:0]        regWData;
  logic               strWe;
  logic [7:0]         strWData;
  logic [STR_AW-1:0]  strRAddr;
  logic [7:0]         strRData;
  logic               strLast;

  // byte source: stored function memory while a function runs, else host
  assign hostReady = (state_r == S_GET) && !inFunc_r;
  assign gotByte = (hostReady && hostValid) || (state_r == S_FWAIT);
  assign gotData = inFunc_r ? fData : hostData;
  assign gotNib = gotData[7:4];
  assign gotLo = gotData[3:0];
  assign opNib = op_r[7:4];
  assign opLo = op_r[3:0];

  assign isLoad = (op_r[7:2] == `FPC_OP_SB >> 2);
  assign isTextIn = (op_r == `FPC_OP_T2R) || (op_r == `FPC_OP_T2I);
  assign isTextOut = (op_r == `FPC_OP_R2T) || (op_r == `FPC_OP_I2T);
  assign toReg0 = (op_r == `FPC_OP_TOREAL) || (op_r == `FPC_OP_TOINT)
                  || isLoad || isTextIn;
  assign isCond = (gotData >= `FPC_XCOND_LO) && (gotData <= `FPC_XCOND_HI);
  assign ldVal = (op_r == `FPC_OP_SB) ? {{24{word_r[7]}}, word_r[7:0]} :
                 (op_r == `FPC_OP_UB) ? {24'h000000, word_r[7:0]} :
                 (op_r == `FPC_OP_SH) ? {{16{word_r[15]}}, word_r[15:0]} :
                                        {16'h0000, word_r[15:0]};
  assign opAddr = (opNib == `FPC_G_RD) ? opLo : opSel_r;

  // status sources: real/int of acc or operand, or their comparison
  assign statCode = (op_r == `FPC_OP_FCMP)  ? `FPC_SC_FCMP :
                    (op_r == `FPC_OP_FSTAT) ? `FPC_SC_FA : xop_r[2:0];
  assign condMatch = (statByte == word_r[7:0]);

  assign fAddr = (state_r == S_HDR0) ? FMEM_AW'({fn_r, 1'b0}) :
                 (state_r == S_HDR1) ? FMEM_AW'({fn_r, 1'b1}) : pc_r;
  assign regRAddr = (state_r == S_RDA) ? accSel_r : opAddr;
  assign regWe = (state_r == S_WB && !isTextOut) || (state_r == S_WB2);
  assign regWAddr = (state_r == S_WB2) ? `FPC_REG_ZERO : dest_r;
  assign regWData = (state_r == S_WB2) ? rem_r : wbVal_r;
  assign strLast = &strIdx_r;
  assign strWe = (state_r == S_WB) && isTextOut;
  // the last cell is always a terminator so readout cannot run away
  assign strWData = strLast ? 8'h00 : wbVal_r[7:0];
  assign strRAddr = strIdx_r;

  assign outValid = (state_r == S_SEND);
  assign outData = word_r[31:24];
  assign mathReq = (state_r == S_MATH);
  assign mathOp = op_r;
  assign mathArgA = mA_r;
  assign mathArgB = mB_r;
  // ready only while idle and waiting on the host, never mid-function
  assign busy = !((state_r == S_GET || state_r == S_SEND) && !inFunc_r);

  always_comb begin
    state_nxt = state_r;
    want_nxt = want_r;
    op_nxt = op_r;
    xop_nxt = xop_r;
    accSel_nxt = accSel_r;
    opSel_nxt = opSel_r;
    cnt_nxt = cnt_r;
    word_nxt = word_r;
    accVal_nxt = accVal_r;
    mA_nxt = mA_r;
    mB_nxt = mB_r;
    wbVal_nxt = wbVal_r;
    rem_nxt = rem_r;
    dest_nxt = dest_r;
    pc_nxt = pc_r;
    len_nxt = len_r;
    inFunc_nxt = inFunc_r;
    fn_nxt = fn_r;
    strIdx_nxt = strIdx_r;
    case (state_r)
      S_GET: begin
        if (inFunc_r && len_r == 8'h00) begin
          inFunc_nxt = 1'b0;
        end else if (inFunc_r) begin
          state_nxt = S_FWAIT;
        end
      end
      S_FWAIT: begin
        pc_nxt = pc_r + 1'b1;
        len_nxt = len_r - 8'h01;
        state_nxt = S_GET;
      end
      S_HDR0: state_nxt = S_HDR1;
      S_HDR1: begin
        pc_nxt = FMEM_AW'({fData, 2'b00});
        state_nxt = S_HDR2;
      end
      S_HDR2: begin
        len_nxt = fData;
        inFunc_nxt = 1'b1;
        state_nxt = S_GET;
      end
      S_RDA: state_nxt = S_RDB;
      S_RDB: begin
        accVal_nxt = regRData;
        state_nxt = S_EXEC;
      end
      S_EXEC: begin
        state_nxt = S_GET;
        mA_nxt = accVal_r;
        mB_nxt = regRData;
        dest_nxt = accSel_r;
        case (opNib)
          `FPC_G_WRA, `FPC_G_WRB: begin
            wbVal_nxt = word_r;
            dest_nxt = (opNib == `FPC_G_WRA) ? accSel_r : opSel_r;
            state_nxt = S_WB;
          end
          `FPC_G_RD: begin
            word_nxt = regRData;
            cnt_nxt = `FPC_ARG_WORD;
            state_nxt = S_SEND;
          end
          `FPC_G_SET: begin
            wbVal_nxt = regRData;
            state_nxt = S_WB;
          end
          `FPC_G_UNARY: state_nxt = S_MATH;
          `FPC_G_MISC: begin
            if (op_r == `FPC_OP_FCMP || op_r == `FPC_OP_FSTAT) begin
              word_nxt = {statByte, 24'h000000};
              cnt_nxt = `FPC_ARG_BYTE;
              state_nxt = S_SEND;
            end else if (op_r == `FPC_OP_XPFX) begin
              // a host-sent conditional is consumed and has no effect
              if (inFunc_r && !condMatch) begin
                inFunc_nxt = 1'b0;
              end
            end else if (isLoad) begin
              mA_nxt = ldVal;
              state_nxt = S_MATH;
            end else if (isTextOut) begin
              strIdx_nxt = '0;
              mB_nxt = {24'h000000, word_r[7:0]};
              state_nxt = S_MATH;
            end else if (toReg0) begin
              state_nxt = S_MATH;
            end
          end
          default: state_nxt = S_MATH;
        endcase
      end
      S_MATH: begin
        if (mathDone) begin
          wbVal_nxt = mathRes;
          rem_nxt = mathRem;
          dest_nxt = toReg0 ? `FPC_REG_ZERO : accSel_r;
          state_nxt = S_WB;
          if (isTextIn && word_r[7:0] != 8'h00) begin
            state_nxt = S_GET;
          end else if (isTextIn) begin
            want_nxt = W_OPC;
          end
        end
      end
      S_WB: begin
        state_nxt = S_GET;
        if (isTextOut && !(wbVal_r[7:0] == 8'h00 || strLast)) begin
          strIdx_nxt = strIdx_r + 1'b1;
          mB_nxt[15:8] = 8'(strIdx_r + 1'b1);
          state_nxt = S_MATH;
        end else if (!isTextOut && opNib == `FPC_G_INT_QUOTIENT_REM) begin
          state_nxt = S_WB2;
        end
      end
      S_WB2: state_nxt = S_GET;
      S_SEND: begin
        if (outReady && cnt_r != 2'd0) begin
          word_nxt = {word_r[23:0], 8'h00};
          cnt_nxt = cnt_r - 2'd1;
        end else if (outReady) begin
          state_nxt = S_GET;
          if (op_r == `FPC_OP_TXTRD && word_r[31:24] != 8'h00
              && !strLast) begin
            strIdx_nxt = strIdx_r + 1'b1;
            state_nxt = S_STR0;
          end
        end
      end
      S_STR0: state_nxt = S_STR1;
      S_STR1: begin
        word_nxt = {strRData, 24'h000000};
        cnt_nxt = `FPC_ARG_BYTE;
        state_nxt = S_SEND;
      end
      default: state_nxt = S_GET;
    endcase

    if (gotByte) begin
      case (want_r)
        W_OPC: begin
          op_nxt = gotData;
          state_nxt = S_GET;
          case (gotNib)
            `FPC_G_SELA: accSel_nxt = gotLo;
            `FPC_G_SELB: opSel_nxt = gotLo;
            `FPC_G_WRA, `FPC_G_WRB: begin
              if (gotNib == `FPC_G_WRA) begin
                accSel_nxt = gotLo;
              end else begin
                opSel_nxt = gotLo;
              end
              cnt_nxt = `FPC_ARG_WORD;
              want_nxt = W_ARG;
            end
            `FPC_G_MISC: begin
              case (gotData)
                `FPC_OP_SYNC: begin
                  word_nxt = {`FPC_SYNC_ACK, 24'h000000};
                  cnt_nxt = `FPC_ARG_BYTE;
                  state_nxt = S_SEND;
                end
                `FPC_OP_SB, `FPC_OP_UB, `FPC_OP_R2T, `FPC_OP_I2T: begin
                  cnt_nxt = `FPC_ARG_BYTE;
                  want_nxt = W_ARG;
                end
                `FPC_OP_SH, `FPC_OP_SH + 8'h01: begin
                  cnt_nxt = `FPC_ARG_HALF;
                  want_nxt = W_ARG;
                end
                `FPC_OP_TXTRD: begin
                  strIdx_nxt = '0;
                  state_nxt = S_STR0;
                end
                `FPC_OP_T2R, `FPC_OP_T2I: want_nxt = W_TEXT;
                `FPC_OP_XPFX: want_nxt = W_XOP;
                `FPC_OP_TOREAL, `FPC_OP_TOINT, `FPC_OP_FCMP,
                `FPC_OP_FSTAT: state_nxt = S_RDA;
                default: state_nxt = S_GET;
              endcase
            end
            default: begin
              if (gotNib >= `FPC_G_SET && gotNib <= `FPC_G_INT_QUOTIENT_REM) begin
                opSel_nxt = gotLo;
              end
              state_nxt = S_RDA;
            end
          endcase
        end
        W_XOP: begin
          xop_nxt = gotData;
          want_nxt = W_OPC;
          if (gotData[7:6] == 2'b00) begin
            fn_nxt = gotData[5:0];
            state_nxt = S_HDR0;
          end else if (isCond) begin
            cnt_nxt = `FPC_ARG_BYTE;
            want_nxt = W_ARG;
          end
        end
        W_ARG: begin
          word_nxt = {word_r[23:0], gotData};
          if (cnt_r == 2'd0) begin
            want_nxt = W_OPC;
            state_nxt = S_RDA;
          end else begin
            cnt_nxt = cnt_r - 2'd1;
          end
        end
        W_TEXT: begin
          word_nxt = {24'h000000, gotData};
          mA_nxt = {24'h000000, gotData};
          mB_nxt = 32'h00000000;
          state_nxt = S_MATH;
        end
        default: want_nxt = W_OPC;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= S_GET;
      want_r <= W_OPC;
      op_r <= 8'hff;
      xop_r <= 8'h00;
      accSel_r <= 4'h0;
      opSel_r <= 4'h0;
      cnt_r <= 2'd0;
      word_r <= 32'h00000000;
      accVal_r <= 32'h00000000;
      mA_r <= 32'h00000000;
      mB_r <= 32'h00000000;
      wbVal_r <= 32'h00000000;
      rem_r <= 32'h00000000;
      dest_r <= 4'h0;
      pc_r <= '0;
      len_r <= 8'h00;
      inFunc_r <= 1'b0;
      fn_r <= 6'h00;
      strIdx_r <= '0;
    end else begin
      state_r <= state_nxt;
      want_r <= want_nxt;
      op_r <= op_nxt;
      xop_r <= xop_nxt;
      accSel_r <= accSel_nxt;
      opSel_r <= opSel_nxt;
      cnt_r <= cnt_nxt;
      word_r <= word_nxt;
      accVal_r <= accVal_nxt;
      mA_r <= mA_nxt;
      mB_r <= mB_nxt;
      wbVal_r <= wbVal_nxt;
      rem_r <= rem_nxt;
      dest_r <= dest_nxt;
      pc_r <= pc_nxt;
      len_r <= len_nxt;
      inFunc_r <= inFunc_nxt;
      fn_r <= fn_nxt;
      strIdx_r <= strIdx_nxt;
    end
  end

  fpc_mem #(.W(32), .AW(4)) regFile (
    .clock (clock),
    .we    (regWe),
    .waddr (regWAddr),
    .wdata (regWData),
    .raddr (regRAddr),
    .rdata (regRData)
  );

  fpc_mem #(.W(8), .AW(FMEM_AW)) funcMem (
    .clock (clock),
    .we    (progWe),
    .waddr (progAddr),
    .wdata (progData),
    .raddr (fAddr),
    .rdata (fData)
  );

  fpc_mem #(.W(8), .AW(STR_AW)) textBuf (
    .clock (clock),
    .we    (strWe),
    .waddr (strIdx_r),
    .wdata (strWData),
    .raddr (strRAddr),
    .rdata (strRData)
  );

  fpc_status_eval statEval (
    .valA   (accVal_r),
    .valB   (regRData),
    .code   (statCode),
    .status (statByte)
  );
endmodule

// ---- include/fpc_map.svh ----
// opcode, field and status bit constants for the opcode decoder
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FPC_G_SELA    4'h0
`define FPC_G_SELB    4'h1
`define FPC_G_WRA     4'h2
`define FPC_G_WRB     4'h3
`define FPC_G_RD      4'h4
`define FPC_G_SET     4'h5
`define FPC_G_INT_QUOTIENT_REM    4'hd
`define FPC_G_UNARY   4'he
`define FPC_G_MISC    4'hf
`define FPC_OP_SYNC   8'hf0
`define FPC_OP_TOREAL 8'hf1
`define FPC_OP_TOINT  8'hf2
`define FPC_OP_FCMP   8'hf3
`define FPC_OP_SB     8'hf4
`define FPC_OP_UB     8'hf5
`define FPC_OP_SH     8'hf6
`define FPC_OP_TXTRD  8'hf8
`define FPC_OP_T2R    8'hf9
`define FPC_OP_R2T    8'hfa
`define FPC_OP_T2I    8'hfb
`define FPC_OP_I2T    8'hfc
`define FPC_OP_FSTAT  8'hfd
`define FPC_OP_XPFX   8'hfe
`define FPC_SYNC_ACK  8'h5c
`define FPC_XCOND_LO  8'h80
`define FPC_XCOND_HI  8'h84
`define FPC_ARG_WORD  2'd3
`define FPC_ARG_HALF  2'd1
`define FPC_ARG_BYTE  2'd0
`define FPC_REG_ZERO  4'h0
`define FPC_ST_ZERO   0
`define FPC_ST_SIGN   1
`define FPC_ST_INF    2
`define FPC_ST_NAN    3
`define FPC_CMP_EQ    0
`define FPC_CMP_LT    1
`define FPC_SC_FA     3'd0
`define FPC_SC_FB     3'd1
`define FPC_SC_FCMP   3'd2
`define FPC_SC_LA     3'd3
`define FPC_SC_LB     3'd4
`endif

// ---- include/fpc_pkg.sv ----
// types shared by the opcode decoder files
package fpc_pkg;
  typedef enum logic [13:0] {
    S_GET   = 14'h0001,
    S_FWAIT = 14'h0002,
    S_HDR0  = 14'h0004,
    S_HDR1  = 14'h0008,
    S_HDR2  = 14'h0010,
    S_RDA   = 14'h0020,
    S_RDB   = 14'h0040,
    S_EXEC  = 14'h0080,
    S_MATH  = 14'h0100,
    S_WB    = 14'h0200,
    S_WB2   = 14'h0400,
    S_SEND  = 14'h0800,
    S_STR0  = 14'h1000,
    S_STR1  = 14'h2000
  } fpc_state_e;
  typedef enum logic [3:0] {
    W_OPC  = 4'h1,
    W_XOP  = 4'h2,
    W_ARG  = 4'h4,
    W_TEXT = 4'h8
  } fpc_want_e;
endpackage

// ---- src/fpc_mem.sv ----
// small synchronous memory with a registered read port
`timescale 1ns/1ps
module fpc_mem #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  input  wire logic          clock,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ---- src/fpc_status_eval.sv ----
// status byte for real and integer values, comparison byte for real values
`timescale 1ns/1ps
`include "fpc_map.svh"
module fpc_status_eval (
  input  wire logic [31:0] valA,
  input  wire logic [31:0] valB,
  input  wire logic [2:0]  code,
  output logic      [7:0]  status
);
  function automatic logic [7:0] realStat(input logic [31:0] v);
    logic expMax;
    logic fracZero;
    expMax = &v[30:23];
    fracZero = ~|v[22:0];
    realStat = 8'h00;
    realStat[`FPC_ST_ZERO] = ~|v[30:0];
    realStat[`FPC_ST_SIGN] = v[31];
    realStat[`FPC_ST_INF] = expMax & fracZero;
    realStat[`FPC_ST_NAN] = expMax & ~fracZero;
  endfunction

  function automatic logic [7:0] intStat(input logic [31:0] v);
    intStat = 8'h00;
    intStat[`FPC_ST_ZERO] = ~|v;
    intStat[`FPC_ST_SIGN] = v[31];
  endfunction

  logic [7:0] stA;
  logic [7:0] stB;
  logic       bothZero;
  logic       isEq;
  logic       isLt;
  logic [7:0] cmpByte;

  assign stA = realStat(valA);
  assign stB = realStat(valB);
  assign bothZero = stA[`FPC_ST_ZERO] & stB[`FPC_ST_ZERO];
  assign isEq = (valA == valB) | bothZero;
  // sign-magnitude order: negative values compare reversed
  assign isLt = bothZero ? 1'b0 :
                (valA[31] != valB[31]) ? valA[31] :
                valA[31] ? (valA[30:0] > valB[30:0]) :
                           (valA[30:0] < valB[30:0]);
  always_comb begin
    cmpByte = 8'h00;
    cmpByte[`FPC_ST_NAN] = stA[`FPC_ST_NAN] | stB[`FPC_ST_NAN];
    cmpByte[`FPC_CMP_EQ] = isEq & ~cmpByte[`FPC_ST_NAN];
    cmpByte[`FPC_CMP_LT] = isLt & ~cmpByte[`FPC_ST_NAN];
  end

  always_comb begin
    case (code)
      `FPC_SC_FA:   status = stA;
      `FPC_SC_FB:   status = stB;
      `FPC_SC_FCMP: status = cmpByte;
      `FPC_SC_LA:   status = intStat(valA);
      `FPC_SC_LB:   status = intStat(valB);
      default:      status = 8'h00;
    endcase
  end
endmodule

// ---- test/fpc_opcode_decode_assertions.sv ----
// port checks for the opcode decoder
`timescale 1ns/1ps
module fpc_opcode_decode_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hostValid,
  input wire logic [7:0]  hostData,
  input wire logic        hostReady,
  input wire logic        outValid,
  input wire logic [7:0]  outData,
  input wire logic        outReady,
  input wire logic        busy,
  input wire logic        mathReq,
  input wire logic [7:0]  mathOp,
  input wire logic [31:0] mathArgA,
  input wire logic        mathDone
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] pend_r;
  logic [7:0] arg_r;
  logic [7:0] op_r;
  logic [2:0] outCnt_r;
  wire take = hostValid & hostReady;
  wire isOp = take & (pend_r == 3'h0);
  // argument counts, so fixed argument bytes are not taken for opcodes; text and conditional bytes are not counted
  wire [2:0] argNum = (hostData[7:5] == 3'h1) ? 3'h4 :
    (hostData inside {8'hf6, 8'hf7}) ? 3'h2 :
    (hostData inside {8'hf4, 8'hf5, 8'hfa, 8'hfc, 8'hfe}) ? 3'h1 : 3'h0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= 3'h0;
      op_r <= 8'hff;
      outCnt_r <= 3'h0;
    end else begin
      if (isOp) begin
        pend_r <= argNum;
        op_r <= hostData;
        outCnt_r <= 3'h0;
      end else if (take) begin
        pend_r <= pend_r - 3'h1;
        arg_r <= hostData;
      end
      if (outValid && outReady && !isOp)
        outCnt_r <= outCnt_r + 3'h1;
    end
  end
  chk_sync_answer: assert property (
    isOp && hostData == 8'hf0 |=> outValid && outData == 8'h5c)
    else $error("sync did not answer 5c");
  chk_out_held: assert property (
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("result byte changed before taken");
  chk_out_blocks_host: assert property (
    outValid |-> !hostReady)
    else $error("host byte taken while result pending");
  chk_read_four: assert property (
    isOp && op_r[7:4] == 4'h4 |-> outCnt_r == 3'h4)
    else $error("register read did not return four bytes");
  chk_math_busy: assert property (
    mathReq |-> busy && !hostReady)
    else $error("math request while not busy");
  chk_idle_state: assert property (
    !busy |-> hostReady || outValid)
    else $error("not busy yet not waiting");
  chk_math_hold: assert property (
    mathReq && !mathDone |=> mathReq && $stable(mathOp)
      && $stable(mathArgA))
    else $error("math request changed before done");
  chk_div_issue: assert property (
    isOp && hostData[7:4] == 4'hd |=> ##[0:20] mathReq && mathOp == op_r)
    else $error("divide not issued");
  chk_load_extend: assert property (
    mathReq && mathOp inside {8'hf4, 8'hf5} |->
      mathArgA == {{24{!mathOp[0] && arg_r[7]}}, arg_r})
    else $error("byte load badly extended");
endmodule
bind fpc_opcode_decode fpc_opcode_decode_assertions chk (
  .clock(clock), .rst(rst), .hostValid(hostValid), .hostData(hostData),
  .hostReady(hostReady), .outValid(outValid), .outData(outData),
  .outReady(outReady), .busy(busy), .mathReq(mathReq), .mathOp(mathOp),
  .mathArgA(mathArgA), .mathDone(mathDone));

// ---- test/fpc_math_model.sv ----
// behavioural math engine facing the decoder
`timescale 1ns/1ps
module fpc_math_model #(
  parameter int LAT = 2
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        mathReq,
  input  wire logic [7:0]  mathOp,
  input  wire logic [31:0] mathArgA,
  input  wire logic [31:0] mathArgB,
  output logic             mathDone,
  output logic      [31:0] mathRes,
  output logic      [31:0] mathRem
);
  logic [7:0]  cnt_r;
  logic [31:0] res_r;
  logic [31:0] rem_r;
  logic [31:0] resNxt;
  wire signed [31:0] a = mathArgA;
  wire signed [31:0] b = mathArgB;
  wire signed [31:0] remNxt = (b != 0) ? a % b : 0;
  // loads pass the extended value through as their result
  assign resNxt = (mathOp[7:4] == 4'ha) ? a + b :
    (mathOp[7:4] == 4'hb) ? a - b :
    (mathOp[7:4] == 4'hc) ? a * b :
    (mathOp[7:4] == 4'hd && b != 0) ? a / b : a;
  // outside the answer cycle the lines show no stale value
  assign mathRes = mathDone ? res_r : ~res_r;
  assign mathRem = mathDone ? rem_r : ~rem_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      mathDone <= 1'b0;
    end else if (mathDone) begin
      mathDone <= 1'b0;
      cnt_r <= 8'h00;
    end else if (mathReq) begin
      cnt_r <= cnt_r + 8'h01;
      mathDone <= (cnt_r == 8'(LAT));
      res_r <= resNxt;
      rem_r <= remNxt;
    end
  end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hostValid = 1'b0;
  logic [7:0]  hostData = 8'h00;
  logic        outReady = 1'b0;
  logic        progWe = 1'b0;
  logic [9:0]  progAddr;
  logic [7:0]  progData;
  logic        hostReady;
  logic        outValid;
  logic        busy;
  logic        mathReq;
  logic        mathDone;
  logic [7:0]  outData;
  logic [7:0]  mathOp;
  logic [31:0] mathArgA;
  logic [31:0] mathArgB;
  logic [31:0] mathRes;
  logic [31:0] mathRem;
  int          num_errors = 0;
  int          compares = 0;
  always #4 clock = ~clock;
  fpc_opcode_decode dut (.clock(clock), .rst(rst), .hostValid(hostValid),
    .hostData(hostData), .hostReady(hostReady), .outValid(outValid),
    .outData(outData), .outReady(outReady), .busy(busy),
    .mathReq(mathReq), .mathOp(mathOp), .mathArgA(mathArgA),
    .mathArgB(mathArgB), .mathDone(mathDone), .mathRes(mathRes),
    .mathRem(mathRem), .progWe(progWe), .progAddr(progAddr),
    .progData(progData));
  fpc_math_model #(.LAT(3)) engine (.clock(clock), .rst(rst),
    .mathReq(mathReq), .mathOp(mathOp), .mathArgA(mathArgA),
    .mathArgB(mathArgB), .mathDone(mathDone), .mathRes(mathRes),
    .mathRem(mathRem));
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic waitHigh(ref logic sig);
    for (int i = 0; i < 300 && sig !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (sig !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask
  // valid stays up between bytes only while hostReady stays high
  task automatic sendByte(input logic [7:0] b);
    outReady = 1'b0;
    if (hostReady !== 1'b1)
      hostValid = 1'b0;
    waitHigh(hostReady);
    hostValid = 1'b1;
    hostData = b;
    @(posedge clock);
    #1;
  endtask
  task automatic recvByte(output logic [7:0] b);
    hostValid = 1'b0;
    waitHigh(outValid);
    b = outData;
    outReady = 1'b1;
    @(posedge clock);
    #1;
  endtask
  task automatic putReg(input logic [7:0] op, input logic [31:0] v);
    sendByte(op);
    for (int i = 3; i >= 0; i--)
      sendByte(v[8*i +: 8]);
  endtask
  task automatic getReg(input logic [3:0] r, output logic [31:0] v);
    logic [7:0] b;
    sendByte({4'h4, r});
    for (int i = 0; i < 4; i++) begin
      recvByte(b);
      v = {v[23:0], b};
    end
  endtask
  task automatic testSync;
    logic [7:0] b;
    sendByte(8'hf0);
    recvByte(b);
    check(b, 8'h5c);
    sendByte(8'hff);
    sendByte(8'hf0);
    recvByte(b);
    check(b, 8'h5c);
    $display("sync test done");
  endtask
  task automatic testRegs;
    logic [31:0] v;
    for (int r = 0; r < 16; r++)
      putReg({r[0] ? 4'h3 : 4'h2, 4'(r)}, 32'h0badcafe ^ {8{4'(r)}});
    for (int r = 0; r < 16; r++) begin
      getReg(4'(r), v);
      check(v, 32'h0badcafe ^ {8{4'(r)}});
    end
    putReg(8'h21, 32'h11223344);
    putReg(8'h32, 32'h55667788);
    sendByte(8'h52);
    getReg(4'h1, v);
    check(v, 32'h55667788);
    $display("register test done");
  endtask
  task automatic testInt;
    logic [7:0]  ops [4] = '{8'ha3, 8'hc3, 8'hb3, 8'hd3};
    logic [31:0] bs [4] = '{32'hfffffffd, 32'hfffffffd, 32'hfffffffd, 32'h2};
    logic [31:0] ex [4] = '{32'h4, 32'hfffffff4, 32'hfffffff7, 32'hfffffffc};
    logic [31:0] v;
    putReg(8'h21, 32'h7);
    for (int i = 0; i < 4; i++) begin
      putReg(8'h33, bs[i]);
      sendByte(ops[i]);
      getReg(4'h1, v);
      check(v, ex[i]);
    end
    getReg(4'h0, v);
    check(v, 32'hffffffff);
    $display("integer test done");
  endtask
  task automatic testLoad;
    logic [31:0] ex [4] = '{32'hffffff80, 32'h80, 32'hffff8001, 32'h8001};
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      sendByte(8'hf4 + 8'(i));
      sendByte(8'h80);
      if (i > 1)
        sendByte(8'h01);
      getReg(4'h0, v);
      check(v, ex[i]);
    end
    $display("load test done");
  endtask
  task automatic testStatus;
    logic [31:0] acc [4] = '{32'h0, 32'hbf800000, 32'h7f800000, 32'h7fc00000};
    logic [7:0]  ex [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
    logic [7:0]  b;
    for (int i = 0; i < 4; i++) begin
      putReg(8'h21, acc[i]);
      sendByte(8'hfd);
      recvByte(b);
      check(b, ex[i]);
    end
    $display("status test done");
  endtask
  task automatic testFunc;
    logic [31:0] v;
    progWe = 1'b1;
    for (int i = 0; i < 5; i++) begin
      progAddr = 10'(i);
      progData = (i == 4) ? 8'h53 : 8'(i < 2);
      @(posedge clock);
      #1;
    end
    progWe = 1'b0;
    sendByte(8'hfe);
    sendByte(8'h00);
    getReg(4'h1, v);
    check(v, 32'h2);
    $display("function test done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    testSync();
    testRegs();
    testInt();
    testLoad();
    testStatus();
    testFunc();
    complete_run();
  end
endmodule
